/* shared/pfa_pkg.sv */
package pfa_pkg;
  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int PIN_COUNT = 8;
  localparam int SYNC_STAGES = 2;
  localparam logic CTRL_RESET = 1'h0;
  localparam logic FORCED_OFF = 1'h0;
  localparam logic IOE_DRIVE = 1'h0;
  localparam logic IOE_RELEASE = 1'h1;
  localparam int RC_DIV_HALF = 2;

  // ----------------------------------------
  // pin function selection, ranked by claim
  // ----------------------------------------
  typedef enum logic [2:0] {
    PFA_GEN_IN = 3'h0,
    PFA_GEN_OUT = 3'h1,
    PFA_ALT_IN = 3'h2,
    PFA_ALT_OUT = 3'h3,
    PFA_LCD = 3'h4,
    PFA_OSC = 3'h5
  } pfa_func_t;

  function automatic logic pfa_pulls_allowed(input pfa_func_t f);
    return (f != PFA_LCD) && (f != PFA_OSC);
  endfunction
endpackage

/* rtl/pfa_pin_slice.sv */
// one pin: function selection, control gating, input sync and change detect
module pfa_pin_slice
  import pfa_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // claims and controls
  input wire logic alt_out_claim_in,
  input wire logic alt_out_level_in,
  input wire logic alt_in_claim_in,
  input wire logic lcd_claim_in,
  input wire logic osc_claim_in,
  input wire logic gpio_dir_out_in,
  input wire logic gpio_level_in,
  input wire logic wake_en_in,
  input wire logic pull_high_en_in,
  input wire logic pull_low_en_in,
  input wire logic open_drain_en_in,
  input wire logic port_read_in,
  // pin side
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n_out,
  output logic pull_high_out,
  output logic pull_low_out,
  // core side
  output logic level_out,
  output logic change_out,
  output pfa_func_t func_out
);
  logic [SYNC_STAGES-1:0] sync_q;
  logic seen_q;
  pfa_func_t func_d;
  logic drive_level;
  logic wants_drive;

  // ----------------------------------------
  // function priority
  // ----------------------------------------
  always_comb begin
    if (osc_claim_in) begin
      func_d = PFA_OSC;
    end else if (lcd_claim_in) begin
      func_d = PFA_LCD;
    end else if (alt_out_claim_in) begin
      func_d = PFA_ALT_OUT;
    end else if (alt_in_claim_in) begin
      func_d = PFA_ALT_IN;
    end else if (gpio_dir_out_in) begin
      func_d = PFA_GEN_OUT;
    end else begin
      func_d = PFA_GEN_IN;
    end
  end
  assign func_out = func_d;

  // ----------------------------------------
  // output drive and pull gating
  // ----------------------------------------
  always_comb begin
    wants_drive = (func_d == PFA_ALT_OUT) || (func_d == PFA_GEN_OUT);
    drive_level = (func_d == PFA_ALT_OUT) ? alt_out_level_in : gpio_level_in;
    pin_out = drive_level;
    // open drain drives only the low level
    if (!wants_drive || (open_drain_en_in && drive_level)) begin
      pin_oe_n_out = IOE_RELEASE;
    end else begin
      pin_oe_n_out = IOE_DRIVE;
    end
    pull_high_out = pfa_pulls_allowed(func_d) ? pull_high_en_in : FORCED_OFF;
    pull_low_out = pfa_pulls_allowed(func_d) ? pull_low_en_in : FORCED_OFF;
  end

  // ----------------------------------------
  // input sync and change latch
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[SYNC_STAGES-2:0], pin_in};
    end
  end
  assign level_out = sync_q[SYNC_STAGES-1];

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seen_q <= 1'h0;
    end else if (port_read_in) begin
      seen_q <= sync_q[SYNC_STAGES-1];
    end
  end

  // wake only from general input with the enable set
  assign change_out = (func_d == PFA_GEN_IN) && wake_en_in
                      && (sync_q[SYNC_STAGES-1] != seen_q);
endmodule

/* rtl/pfa_pin_function_arbiter.sv */
module pfa_pin_function_arbiter
  import pfa_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // software controls
  input wire logic ctrl_we_in,
  input wire logic [PINS-1:0] wake_en_wr_in,
  input wire logic [PINS-1:0] pull_high_wr_in,
  input wire logic [PINS-1:0] pull_low_wr_in,
  input wire logic [PINS-1:0] open_drain_wr_in,
  input wire logic [PINS-1:0] gpio_dir_out_in,
  input wire logic [PINS-1:0] gpio_level_in,
  input wire logic port_read_in,
  // function claims
  input wire logic [PINS-1:0] alt_out_claim_in,
  input wire logic [PINS-1:0] alt_out_level_in,
  input wire logic [PINS-1:0] alt_in_claim_in,
  input wire logic [PINS-1:0] lcd_claim_in,
  input wire logic [PINS-1:0] osc_claim_in,
  // core state
  input wire logic sleeping_in,
  input wire logic rc_mode_in,
  // pins
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_n_out,
  output logic [PINS-1:0] pull_high_out,
  output logic [PINS-1:0] pull_low_out,
  output logic main_oscillator_output_out,
  output logic main_oscillator_output_oe_n_out,
  // core side
  output logic [PINS-1:0] port_level_out,
  output logic [PINS-1:0] pin_change_out,
  output logic wake_out,
  output logic core_reset_out,
  output logic [PINS-1:0] wake_en_out
);
  logic [PINS-1:0] wake_en_q;
  logic [PINS-1:0] pull_high_q;
  logic [PINS-1:0] pull_low_q;
  logic [PINS-1:0] open_drain_q;
  logic wake_q;
  logic [1:0] rst_sync_q;
  logic [1:0] div_q;
  logic icyc_q;

  // ----------------------------------------
  // software control bits
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wake_en_q <= {PINS{CTRL_RESET}};
      pull_high_q <= {PINS{CTRL_RESET}};
      pull_low_q <= {PINS{CTRL_RESET}};
      open_drain_q <= {PINS{CTRL_RESET}};
    end else if (ctrl_we_in) begin
      wake_en_q <= wake_en_wr_in;
      pull_high_q <= pull_high_wr_in;
      pull_low_q <= pull_low_wr_in;
      open_drain_q <= open_drain_wr_in;
    end
  end
  assign wake_en_out = wake_en_q;

  // ----------------------------------------
  // per-pin slices
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      pfa_pin_slice u_slice (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .alt_out_claim_in(alt_out_claim_in[gi]),
        .alt_out_level_in(alt_out_level_in[gi]),
        .alt_in_claim_in(alt_in_claim_in[gi]),
        .lcd_claim_in(lcd_claim_in[gi]),
        .osc_claim_in(osc_claim_in[gi]),
        .gpio_dir_out_in(gpio_dir_out_in[gi]),
        .gpio_level_in(gpio_level_in[gi]),
        .wake_en_in(wake_en_q[gi]),
        .pull_high_en_in(pull_high_q[gi]),
        .pull_low_en_in(pull_low_q[gi]),
        .open_drain_en_in(open_drain_q[gi]),
        .port_read_in(port_read_in),
        .pin_in(pin_in[gi]),
        .pin_out(pin_out[gi]),
        .pin_oe_n_out(pin_oe_n_out[gi]),
        .pull_high_out(pull_high_out[gi]),
        .pull_low_out(pull_low_out[gi]),
        .level_out(port_level_out[gi]),
        .change_out(pin_change_out[gi]),
        .func_out()
      );
    end
  endgenerate

  // ----------------------------------------
  // wake request
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wake_q <= 1'h0;
    end else begin
      wake_q <= sleeping_in && (|pin_change_out);
    end
  end
  assign wake_out = wake_q;

  // ----------------------------------------
  // reset hold
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign core_reset_out = !rst_sync_q[1];

  // ----------------------------------------
  // instruction clock out in rc mode
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_q <= 2'h0;
      icyc_q <= 1'h0;
    end else if (div_q == 2'(RC_DIV_HALF - 1)) begin
      div_q <= 2'h0;
      icyc_q <= !icyc_q;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign main_oscillator_output_out = icyc_q;
  assign main_oscillator_output_oe_n_out = rc_mode_in ? IOE_DRIVE : IOE_RELEASE;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_wake_forced;
    @(posedge clk_in) disable iff (!resetn_in)
    (|(pin_change_out & (alt_in_claim_in | alt_out_claim_in | lcd_claim_in
      | osc_claim_in | gpio_dir_out_in))) == 1'b0;
  endproperty
  a_wake_forced: assert property (p_wake_forced) else $error("wake not forced off");

  property p_pull_forced;
    @(posedge clk_in) disable iff (!resetn_in)
    ((pull_high_out | pull_low_out) & (lcd_claim_in | osc_claim_in)) == '0;
  endproperty
  a_pull_forced: assert property (p_pull_forced) else $error("pull not forced off");

  property p_wake_follows;
    @(posedge clk_in) disable iff (!resetn_in)
    (sleeping_in && |pin_change_out) |=> wake_out;
  endproperty
  a_wake_follows: assert property (p_wake_follows) else $error("wake missed");

  property p_alt_out_wins;
    @(posedge clk_in) disable iff (!resetn_in)
    (alt_out_claim_in[0] && !lcd_claim_in[0] && !osc_claim_in[0] && !open_drain_q[0])
      |-> (!pin_oe_n_out[0] && pin_out[0] == alt_out_level_in[0]);
  endproperty
  a_alt_out_wins: assert property (p_alt_out_wins) else $error("alt output lost");

  property p_rc_clock;
    @(posedge clk_in) disable iff (!resetn_in)
    rc_mode_in |-> !main_oscillator_output_oe_n_out;
  endproperty
  a_rc_clock: assert property (p_rc_clock) else $error("rc clock not driven");

  property p_ctrl_hold;
    @(posedge clk_in) disable iff (!resetn_in)
    !ctrl_we_in |=> $stable(wake_en_q) && $stable(pull_high_q);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed unwritten");

  property p_reset_release;
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(rst_sync_q[0]) |-> core_reset_out ##1 !core_reset_out;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset hold wrong");

  property p_ph_pass;
    @(posedge clk_in) disable iff (!resetn_in)
    (!lcd_claim_in[0] && !osc_claim_in[0]) |-> pull_high_out[0] == pull_high_q[0];
  endproperty
  a_ph_pass: assert property (p_ph_pass) else $error("pull-high not passed");

  property p_reset_hold;
    @(posedge clk_in)
    !resetn_in |-> core_reset_out;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset not held");

  property p_ctrl_cleared;
    @(posedge clk_in)
    !resetn_in |-> (wake_en_q | pull_high_q | pull_low_q | open_drain_q) == '0;
  endproperty
  a_ctrl_cleared: assert property (p_ctrl_cleared) else $error("controls not cleared");

  property p_alt_in_wins;
    @(posedge clk_in) disable iff (!resetn_in)
    (alt_in_claim_in[0] && !alt_out_claim_in[0] && !lcd_claim_in[0] && !osc_claim_in[0])
      |-> pin_oe_n_out[0];
  endproperty
  a_alt_in_wins: assert property (p_alt_in_wins) else $error("alt input lost");
endmodule

/* dv/pfa_pin_model.sv */
// board side of the pins: external drivers, pull resistors, floating lines
module pfa_pin_model
  import pfa_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  // clock
  input wire logic clk_in,
  // device side
  input wire logic [PINS-1:0] pin_out_in,
  input wire logic [PINS-1:0] pin_oe_n_in,
  input wire logic [PINS-1:0] pull_high_in,
  input wire logic [PINS-1:0] pull_low_in,
  // board drivers
  input wire logic [PINS-1:0] ext_en_in,
  input wire logic [PINS-1:0] ext_level_in,
  // resolved pad level
  output logic [PINS-1:0] pad_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PINS-1:0] last_q = '0;
  // a floating pad wanders: shows the inverse of its last level every cycle
  always_ff @(posedge clk_in) begin
    last_q <= pad_out;
  end
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (pin_oe_n_in[i] == IOE_DRIVE) pad_out[i] = pin_out_in[i];
      else if (ext_en_in[i]) pad_out[i] = ext_level_in[i];
      else if (pull_high_in[i]) pad_out[i] = 1'h1;
      else if (pull_low_in[i]) pad_out[i] = 1'h0;
      else pad_out[i] = ~last_q[i];
    end
  end
endmodule

/* dv/test_pin_function_arbiter.sv */
module test_pin_function_arbiter;
  timeunit 1ns;
  timeprecision 1ns;
  import pfa_pkg::*;
  localparam int P = PIN_COUNT;
  logic clk_in = 1, resetn_in = 1, we = 0, prd = 0, slp = 0, rc = 0;
  logic [P-1:0] wk = 0, ph = 0, pl = 0, od = 0, gd = 0, gl = 0, ao = 0, al = 0, ai = 0;
  logic [P-1:0] lcd = 0, osc = 0, pad, po, poe, pho, plo, lvl, chg, wen, xen = 0, xlv = 0;
  logic mo, moe, wake, crst, a;
  logic [1:0] e;
  int mismatches = 0, cmp_count = 0, cyc = 0, seed = 32'hd77d;
  pfa_pin_function_arbiter #(.PINS(P)) pfa_pin_function_arbiter_inst (.clk_in(clk_in),
    .resetn_in(resetn_in), .ctrl_we_in(we), .wake_en_wr_in(wk), .pull_high_wr_in(ph),
    .pull_low_wr_in(pl), .open_drain_wr_in(od), .gpio_dir_out_in(gd), .gpio_level_in(gl),
    .port_read_in(prd), .alt_out_claim_in(ao), .alt_out_level_in(al), .alt_in_claim_in(ai),
    .lcd_claim_in(lcd), .osc_claim_in(osc), .sleeping_in(slp), .rc_mode_in(rc),
    .pin_in(pad), .pin_out(po), .pin_oe_n_out(poe), .pull_high_out(pho), .pull_low_out(plo),
    .main_oscillator_output_out(mo), .main_oscillator_output_oe_n_out(moe),
    .port_level_out(lvl), .pin_change_out(chg), .wake_out(wake), .core_reset_out(crst),
    .wake_en_out(wen));
  pfa_pin_model #(.PINS(P)) pfa_pin_model_inst (.clk_in(clk_in), .pin_out_in(po),
    .pin_oe_n_in(poe), .pull_high_in(pho), .pull_low_in(plo), .ext_en_in(xen),
    .ext_level_in(xlv), .pad_out(pad));
  // ----------------------------------------
  // clock, timeout, checking
  // ----------------------------------------
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end
  task automatic check(input logic [P-1:0] seen, input logic [P-1:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic wr_ctrl(input logic [P-1:0] w, h, l, o);
    wk = w; ph = h; pl = l; od = o; we = 1;
    cyc_n(1);
    we = 0;
    cyc_n(1);
  endtask
  task automatic pulse_read();
    prd = 1;
    cyc_n(1);
    prd = 0;
  endtask
  // expected {released, level} of one pin from claim priority and open drain
  function automatic logic [1:0] exp_pin(input int i);
    logic lv;
    if (!ao[i] && (ai[i] || !gd[i])) return 2'h2;
    lv = ao[i] ? al[i] : gl[i];
    return {od[i] & lv, lv};
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc_n(1);
    resetn_in = 0;
    cyc_n(10);
    check({7'h0, crst}, 8'h1);
    check(wen | pho | plo, 8'h0);
    cyc_n(10);
    resetn_in = 1;
    cyc_n(3);
    check({7'h0, crst}, 8'h0);
    // random claims, controls and pulls
    repeat (60) begin
      {ao, al, ai, gd} = $random(seed);
      gl = P'($random(seed));
      lcd = P'($random(seed) & $random(seed));
      osc = P'($random(seed) & $random(seed)) & ~lcd;
      wr_ctrl(8'h0, P'($random(seed)), P'($random(seed)), P'($random(seed)));
      check(pho, ph & ~lcd & ~osc);
      check(plo, pl & ~lcd & ~osc);
      for (int i = 0; i < P; i++) begin
        e = exp_pin(i);
        if (!lcd[i] && !osc[i]) begin
          check({7'h0, poe[i]}, {7'h0, e[1]});
          if (!e[1]) check({7'h0, po[i]}, {7'h0, e[0]});
        end
      end
    end
    // pin change wake on a general input
    {ao, ai, gd, lcd, osc} = '0;
    xen = 8'hff;
    xlv = P'($random(seed));
    wr_ctrl(8'h01, 8'h0, 8'h0, 8'h0);
    cyc_n(4);
    pulse_read();
    cyc_n(2);
    check(chg, 8'h0);
    slp = 1;
    xlv[0] = ~xlv[0];
    cyc_n(4);
    check(chg, 8'h01);
    check(lvl, xlv);
    check({7'h0, wake}, 8'h1);
    pulse_read();
    cyc_n(2);
    check({6'h0, chg[0], wake}, 8'h0);
    // wake is forced off once the pin is claimed away from general input
    ai[0] = 1;
    xlv[0] = ~xlv[0];
    cyc_n(4);
    check({7'h0, chg[0]}, 8'h0);
    check({7'h0, wake}, 8'h0);
    pulse_read();
    wr_ctrl(8'h0, 8'h0, 8'h0, 8'h0);
    slp = 0;
    // rc mode clock out
    rc = 1;
    cyc_n(2);
    check({7'h0, moe}, 8'h0);
    a = mo;
    cyc_n(2);
    check({7'h0, mo}, {7'h0, ~a});
    cyc_n(2);
    check({7'h0, mo}, {7'h0, a});
    rc = 0;
    cyc_n(1);
    check({7'h0, moe}, 8'h1);
    // reset in mid-run
    ai = '0;
    wr_ctrl(8'hff, 8'hff, 8'h0, 8'h0);
    check(pho, 8'hff);
    resetn_in = 0;
    cyc_n(2);
    check({7'h0, crst}, 8'h1);
    check(wen | pho | plo, 8'h0);
    resetn_in = 1;
    @(posedge clk_in);
    #1 check({7'h0, crst}, 8'h1);
    @(posedge clk_in);
    #1 check({7'h0, crst}, 8'h0);
    conclude();
  end
endmodule
